// ==== shared/ssw_pkg.sv ====
// constants for the supply supervisor with watchdog
// Summary of operation
// - reset outputs active while the supply-good indication is low.
// - after supply recovers, hold reset at least 130 ms before release.
// - active-low reset output plus complementary active-high reset output.
// - manual reset input is debounced; each press gives at least 130 ms reset.
// - manual-reset stretch starts when the input returns high.
// - sense trip drives power-fail warning low for at least 200 us.
// - sense input must stay below trip about 5 us before warning.
// - no warning until own supply has reached its trip level.
// - watchdog counts only while reset is inactive, starting at release.
// - watchdog expires when no strobe falling edge arrives within 1 s.
// - each strobe falling edge before expiry clears and restarts the watchdog.
// - on expiry the watchdog output is driven low for at least 130 ms.
// - supply dips shorter than 2 us cause neither reset nor warning.
package ssw_pkg;
  // ****************************************
  // timing
  // ****************************************
  localparam int CLOCK_HZ = 40000000;
  localparam int RESET_STRETCH_MS = 130;
  localparam int WARN_PULSE_US = 200;
  localparam int SENSE_FILTER_US = 5;
  localparam int SUPPLY_FILTER_US = 2;
  localparam int WATCHDOG_TIMEOUT_MS = 1000;
  localparam int DEBOUNCE_US = 1;
  localparam int RESET_STRETCH_CYC = (CLOCK_HZ / 1000) * RESET_STRETCH_MS;
  localparam int WARN_PULSE_CYC = (CLOCK_HZ / 1000000) * WARN_PULSE_US;
  localparam int SENSE_FILTER_CYC = (CLOCK_HZ / 1000000) * SENSE_FILTER_US;
  localparam int SUPPLY_FILTER_CYC = (CLOCK_HZ / 1000000) * SUPPLY_FILTER_US;
  localparam int WATCHDOG_TIMEOUT_CYC = (CLOCK_HZ / 1000) * WATCHDOG_TIMEOUT_MS;
  localparam int DEBOUNCE_CYC = (CLOCK_HZ / 1000000) * DEBOUNCE_US;
  localparam int COUNT_W = 32;
  localparam int FILT_W = 8;
endpackage

// ==== rtl/ssw_filter.sv ====
// level filter: output follows input after it has been steady a set time
`timescale 1ns/1ps
`default_nettype none
module ssw_filter
  import ssw_pkg::*;
#(
  parameter int STEADY_CYC = 80,
  parameter logic RESET_LEVEL = 1'b0
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic rawIn,
  output logic filtered
);
  typedef struct packed {
    logic [FILT_W-1:0] count;
    logic level;
  } ssw_filt_type;
  localparam logic [FILT_W-1:0] LAST = FILT_W'(STEADY_CYC - 1);
  ssw_filt_type state;
  ssw_filt_type next_state;
  always_comb begin
    next_state = state;
    if (rawIn == state.level) begin
      next_state.count = '0;
    end else if (state.count >= LAST) begin
      next_state.level = rawIn;
      next_state.count = '0;
    end else begin
      next_state.count = state.count + 8'h01;
    end
  end
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= '{count: '0, level: RESET_LEVEL};
    end else begin
      state <= next_state;
    end
  end
  assign filtered = state.level;
endmodule
`default_nettype wire

// ==== rtl/ssw_supervisor.sv ====
// supervisor top: supply reset, manual reset, power-fail warning, watchdog
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor
  import ssw_pkg::*;
#(
  parameter int STRETCH_CYC = RESET_STRETCH_CYC,
  parameter int TIMEOUT_CYC = WATCHDOG_TIMEOUT_CYC
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic supplyOk,
  input wire logic senseLow,
  input wire logic manual_reset_in_n,
  input wire logic watchdog_strobe_n,
  output logic resetOut_n,
  output logic resetOut,
  output logic powerFailWarn_n,
  output logic watchdog_expired_n
);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic [1:0] supSync;
    logic [1:0] senSync;
    logic [1:0] manSync;
    logic [1:0] stbSync;
    logic stbLast;
    logic senLast;
    logic [COUNT_W-1:0] rstCnt;
    logic [COUNT_W-1:0] wdCnt;
    logic [COUNT_W-1:0] expCnt;
    logic [COUNT_W-1:0] warnCnt;
    logic rstN;
    logic rst;
    logic warnN;
    logic expN;
  } ssw_state_type;

  localparam logic [COUNT_W-1:0] STRETCH = COUNT_W'(STRETCH_CYC);
  localparam logic [COUNT_W-1:0] TIMEOUT = COUNT_W'(TIMEOUT_CYC);
  localparam logic [COUNT_W-1:0] WARN = COUNT_W'(WARN_PULSE_CYC);

  ssw_state_type state;
  ssw_state_type next_state;
  logic supGood;
  logic senTrip;
  logic manHigh;
  logic strobeFell;

  // ****************************************
  // helpers
  // ****************************************
  // counters park at zero so a finished stretch never wraps back to busy
  function automatic logic [COUNT_W-1:0] count_down(input logic [COUNT_W-1:0] value);
    if (value == '0) begin
      count_down = '0;
    end else begin
      count_down = value - 32'h00000001;
    end
  endfunction

  // edge taken after both sync flops, so a metastable pin never kicks twice
  assign strobeFell = state.stbLast && !state.stbSync[1];

  // ****************************************
  // glitch filters
  // ****************************************
  // ignore short dips
  // supply filter resets low, so the power-up stretch waits for a steady good supply
  ssw_filter #(
    .STEADY_CYC(SUPPLY_FILTER_CYC),
    .RESET_LEVEL(1'b0)
  ) uSup (
    .clock(clock),
    .rst_b(rst_b),
    .rawIn(state.supSync[1]),
    .filtered(supGood)
  );
  ssw_filter #(
    .STEADY_CYC(SENSE_FILTER_CYC),
    .RESET_LEVEL(1'b0)
  ) uSen (
    .clock(clock),
    .rst_b(rst_b),
    .rawIn(state.senSync[1]),
    .filtered(senTrip)
  );
  ssw_filter #(
    .STEADY_CYC(DEBOUNCE_CYC),
    .RESET_LEVEL(1'b1)
  ) uMan (
    .clock(clock),
    .rst_b(rst_b),
    .rawIn(state.manSync[1]),
    .filtered(manHigh)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_state = state;
    // two flops on every pin before any logic reads it
    next_state.supSync = {state.supSync[0], supplyOk};
    next_state.senSync = {state.senSync[0], senseLow};
    next_state.manSync = {state.manSync[0], manual_reset_in_n};
    next_state.stbSync = {state.stbSync[0], watchdog_strobe_n};
    next_state.stbLast = state.stbSync[1];
    next_state.senLast = senTrip;
    if (!supGood || !manHigh) begin
      next_state.rstCnt = STRETCH;
    end else begin
      next_state.rstCnt = count_down(state.rstCnt);
    end
    next_state.rstN = (next_state.rstCnt == '0);
    next_state.rst = (next_state.rstCnt != '0);
    if (senTrip && !state.senLast && supGood) begin
      next_state.warnCnt = WARN;
    end else begin
      next_state.warnCnt = count_down(state.warnCnt);
    end
    next_state.warnN = (next_state.warnCnt == '0);
    next_state.expCnt = count_down(state.expCnt);
    if (!state.rstN) begin
      next_state.wdCnt = '0;
    end else if (strobeFell) begin
      next_state.wdCnt = '0;
    end else if (state.wdCnt >= TIMEOUT - 32'h00000001) begin
      // expiry restarts count too
      // a new expiry reloads the pulse, so it wins over the countdown
      next_state.wdCnt = '0;
      next_state.expCnt = STRETCH;
    end else begin
      next_state.wdCnt = state.wdCnt + 32'h00000001;
    end
    next_state.expN = (next_state.expCnt == '0);
  end

  // ****************************************
  // registers
  // ****************************************
  // sync flops reset to the idle pin levels so no false edge follows reset
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      state <= '{
        supSync: 2'h0,
        senSync: 2'h0,
        manSync: 2'h3,
        stbSync: 2'h3,
        stbLast: 1'b1,
        senLast: 1'b0,
        rstCnt: STRETCH,
        wdCnt: '0,
        expCnt: '0,
        warnCnt: '0,
        rstN: 1'b0,
        rst: 1'b1,
        warnN: 1'b1,
        expN: 1'b1
      };
    end else begin
      state <= next_state;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign resetOut_n = state.rstN;
  assign resetOut = state.rst;
  assign powerFailWarn_n = state.warnN;
  assign watchdog_expired_n = state.expN;

  // ****************************************
  // checks
  // ****************************************
  AST_COMPLEMENT: assert property (@(posedge clock) disable iff (!rst_b)
    resetOut != resetOut_n)
    else $error("reset outputs not complementary");
  AST_SUPPLY_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    !supGood |=> !resetOut_n)
    else $error("reset not active on bad supply");
  AST_MANUAL_RESET: assert property (@(posedge clock) disable iff (!rst_b)
    !manHigh |=> !resetOut_n)
    else $error("reset not active on manual");
  AST_STRETCH: assert property (@(posedge clock) disable iff (!rst_b)
    (!supGood || !manHigh) |=> state.rstCnt == STRETCH)
    else $error("stretch not reloaded");
  AST_RELEASE: assert property (@(posedge clock) disable iff (!rst_b)
    $rose(resetOut_n) |-> $past(state.rstCnt) == 32'h00000001)
    else $error("early release");
  AST_RST_WIDTH: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(resetOut_n) |=> !resetOut_n [*8])
    else $error("reset pulse too short");
  AST_DEBOUNCE: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(manHigh) |-> $past(state.manSync[1]) == 1'b0)
    else $error("press not debounced");
  AST_WARN_GATE: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(powerFailWarn_n) |-> $past(supGood))
    else $error("warning with low supply");
  AST_WARN_PULSE: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(powerFailWarn_n) |-> state.warnCnt == WARN)
    else $error("warning pulse length");
  AST_WARN_WIDTH: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(powerFailWarn_n) |=> !powerFailWarn_n [*8])
    else $error("warning pulse too short");
  AST_WARN_FILTER: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(powerFailWarn_n) |-> $past(senTrip))
    else $error("warning without filtered trip");
  AST_WD_HOLD: assert property (@(posedge clock) disable iff (!rst_b)
    !resetOut_n |=> state.wdCnt == '0)
    else $error("watchdog ran in reset");
  AST_WD_KICK: assert property (@(posedge clock) disable iff (!rst_b)
    strobeFell |=> state.wdCnt == '0)
    else $error("strobe not restarting");
  AST_WD_EXPIRE: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(watchdog_expired_n) |-> state.expCnt == STRETCH)
    else $error("expiry pulse length");
  AST_WD_WIDTH: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(watchdog_expired_n) |=> !watchdog_expired_n [*8])
    else $error("expiry pulse too short");
  AST_WD_LIMIT: assert property (@(posedge clock) disable iff (!rst_b)
    state.wdCnt < TIMEOUT)
    else $error("watchdog count past timeout");
  AST_WD_FIRE: assert property (@(posedge clock) disable iff (!rst_b)
    (state.rstN && !strobeFell && state.wdCnt == TIMEOUT - 32'h00000001)
      |=> !watchdog_expired_n)
    else $error("watchdog did not expire");
  AST_SUP_FILTER: assert property (@(posedge clock) disable iff (!rst_b)
    $fell(supGood) |-> $past(state.supSync[1]) == 1'b0)
    else $error("supply dip unfiltered");
endmodule
`default_nettype wire

// ==== bench/ssw_cpu_model.sv ====
// processor model that kicks the watchdog strobe
`timescale 1ns/1ps
`default_nettype none
module ssw_cpu_model (
  input wire logic clock,
  input wire logic kickEn,
  output logic watchdog_strobe_n
);
  int cnt = 0;
  always @(negedge clock) begin
    cnt <= (!kickEn || cnt == 99) ? 0 : cnt + 1;
    watchdog_strobe_n <= !(kickEn && cnt < 4);
  end
endmodule
`default_nettype wire

// ==== bench/ssw_supervisor_tb_top.sv ====
// self-checking bench for the supply supervisor
`timescale 1ns/1ps
`default_nettype none
module ssw_supervisor_tb_top;
  localparam int STR = 100, TMO = 300;
  logic clock = 1'h0, rst_b = 1'h0;
  logic supplyOk = 1'h1, senseLow = 1'h0, manual_reset_in_n = 1'h1, kickEn = 1'h1;
  logic watchdog_strobe_n, resetOut_n, resetOut, powerFailWarn_n, watchdog_expired_n;
  int errors = 0, checks_done = 0, n;
  wire [2:0] outs = {watchdog_expired_n, powerFailWarn_n, resetOut_n};
  always #12.5 clock = ~clock;
  ssw_supervisor #(.STRETCH_CYC(STR), .TIMEOUT_CYC(TMO)) i_dut (
    .clock(clock), .rst_b(rst_b), .supplyOk(supplyOk), .senseLow(senseLow),
    .manual_reset_in_n(manual_reset_in_n), .watchdog_strobe_n(watchdog_strobe_n),
    .resetOut_n(resetOut_n), .resetOut(resetOut), .powerFailWarn_n(powerFailWarn_n),
    .watchdog_expired_n(watchdog_expired_n));
  ssw_cpu_model i_cpu (.clock(clock), .kickEn(kickEn), .watchdog_strobe_n(watchdog_strobe_n));
  task automatic finish_test();
    if (errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic check(input logic ok, input string m);
    checks_done++;
    if (ok !== 1'h1) $display("[FAIL] %0t %s", $time, m);
    errors += int'(ok !== 1'h1);
  endtask
  task automatic hold(input int s, input logic v, input int c, input string m);
    logic ok = 1'h1;
    repeat (c) begin
      @(negedge clock);
      ok &= (outs[s] === v) && (resetOut === ~resetOut_n);
    end
    check(ok, m);
  endtask
  task automatic wait_for(input int s, input logic v, input int lim);
    for (n = 0; outs[s] !== v && n <= lim; n++) @(negedge clock);
    check(n <= lim, "wait limit");
    if (n > lim) finish_test();
  endtask
  task automatic t_supply();
    supplyOk = 1'h0;
    hold(0, 1'h1, 40, "dip reset");
    supplyOk = 1'h1;
    hold(0, 1'h1, 200, "dip reset");
    supplyOk = 1'h0;
    senseLow = 1'h1;
    wait_for(0, 1'h0, 100);
    hold(1, 1'h1, 300, "warn in power-up");
    senseLow = 1'h0;
    hold(1, 1'h1, 250, "warn in power-up");
    supplyOk = 1'h1;
    wait_for(0, 1'h1, 300);
  endtask
  task automatic t_manual();
    manual_reset_in_n = 1'h0;
    wait_for(0, 1'h0, 60);
    supplyOk = 1'h0;
    hold(0, 1'h0, 150, "press reset");
    supplyOk = 1'h1;
    hold(0, 1'h0, 300, "overlap");
    manual_reset_in_n = 1'h1;
    hold(0, 1'h0, 130, "press stretch");
    wait_for(0, 1'h1, 100);
  endtask
  task automatic t_warn();
    senseLow = 1'h1;
    hold(1, 1'h1, 100, "short dip warn");
    senseLow = 1'h0;
    hold(1, 1'h1, 300, "short dip warn");
    senseLow = 1'h1;
    hold(1, 1'h1, 150, "early warn");
    wait_for(1, 1'h0, 100);
    hold(1, 1'h0, ssw_pkg::WARN_PULSE_CYC - 5, "warn width");
    wait_for(1, 1'h1, 20);
  endtask
  task automatic t_watchdog();
    hold(2, 1'h1, 1000, "kicked expiry");
    kickEn = 1'h0;
    wait_for(2, 1'h0, TMO + 20);
    hold(2, 1'h0, STR - 5, "status width");
    wait_for(2, 1'h1, 20);
    manual_reset_in_n = 1'h0;
    hold(2, 1'h1, 600, "timed in reset");
    manual_reset_in_n = 1'h1;
    wait_for(0, 1'h1, 200);
    hold(2, 1'h1, TMO - 20, "timed before release");
    wait_for(2, 1'h0, 40);
  endtask
  task automatic t_powerup();
    rst_b = 1'h1;
    hold(0, 1'h0, 150, "power-up release");
    wait_for(0, 1'h1, 100);
  endtask
  initial begin
    repeat (8) @(negedge clock);
    t_powerup();
    t_supply();
    t_manual();
    t_warn();
    t_watchdog();
    finish_test();
  end
endmodule
`default_nettype wire
